/* File: hdl/adc_sequencer_control_regs.sv */
// Converter control registers, sampling timer and sequencer with AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_consts.svh"

// Notes on behaviour
// - Upper sample time serves slots eight-fifteen.
// - Lower sample time serves slots zero-seven.
// - Sample codes map to 4..768, then 1024.
// - Multi-conversion bit chains conversions after first edge.
// - Reference power bit; level applies only when on.
// - Core power bit switches conversion core.
// - Interrupt enables gated with global enable.
// - Conversion enable bit permits conversions.
// - Software start pulses and self clears.
// - Protected fields change only while disabled.
// - Start slot picks first result slot.
// - Trigger source selects software or timer outputs.
// - Pulse mode: timer or trigger drives sampling.
// - Trigger inversion bit inverts trigger input.
// - Divider divides converter clock by value+1.
// - Clock source selects one of four clocks.
// - Sequence mode chooses one of four modes.
// - Busy bit shows active sequence or conversion.
// - Results right-justified twelve bits; writes corrupt.
// - Slot last bit ends a sequence.
// - Reference select chooses reference pairing per slot.
// - Channel select chooses input per slot.
// - Result overwrite when unread slot is refilled.
// - Time overflow when trigger arrives mid-conversion.
module adc_sequencer_control_regs
   import adc_seq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        clkEnable,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        oscTick,
   input  wire logic        auxTick,
   input  wire logic        mainTick,
   input  wire logic        subMainTick,
   input  wire logic        firstTimerOutputOne,
   input  wire logic        secondTimerOutputZero,
   input  wire logic        secondTimerOutputOne,
   input  wire logic        globalIrqEnable,
   input  wire logic        convDone,
   input  wire logic [11:0] convData,
   output logic             sampleControl,
   output logic             converterClock,
   output logic [3:0]       channelSelect,
   output logic [2:0]       referenceSelect,
   output logic             corePower,
   output logic             referencePower,
   output logic             referenceLevelSelect,
   output logic             converterBusy,
   output logic             overwriteIrq,
   output logic             timeOverflowIrq
);

   state_type s;
   state_type n;

   function automatic logic [10:0] sampleCycles(input logic [3:0] code);
      case (code)
         4'h0:    sampleCycles = 11'h004;
         4'h1:    sampleCycles = 11'h008;
         4'h2:    sampleCycles = 11'h010;
         4'h3:    sampleCycles = 11'h020;
         4'h4:    sampleCycles = 11'h040;
         4'h5:    sampleCycles = 11'h060;
         4'h6:    sampleCycles = 11'h080;
         4'h7:    sampleCycles = 11'h0c0;
         4'h8:    sampleCycles = 11'h100;
         4'h9:    sampleCycles = 11'h180;
         4'ha:    sampleCycles = 11'h200;
         4'hb:    sampleCycles = 11'h300;
         default: sampleCycles = 11'h400;
      endcase
   endfunction

   function automatic logic isMem(input logic [9:0] idx);
      isMem = idx >= `MEM_IDX && idx <= `MEM_LAST && !idx[0];
   endfunction

   function automatic logic isMctl(input logic [9:0] idx);
      isMctl = idx >= `MCTL_IDX && idx <= `MCTL_LAST;
   endfunction

   function automatic logic [3:0] memSlot(input logic [9:0] idx);
      memSlot = idx[4:1];
   endfunction

   logic [9:0]  rdIdx;
   logic        rdReq;
   logic        wrReq;
   logic        srcTick;
   logic        tickNow;
   logic        trigRaw;
   logic        trigIn;
   logic        rise;
   logic        enabled;
   logic        locked;
   logic [3:0]  shtCode;
   logic [10:0] cntInc;
   logic        chainNext;
   logic [1:0]  seqMode;
   logic [31:0] rdVal;

   always_comb begin
      n = s;
      rdIdx = haddr[11:2];
      rdReq = hsel && htrans[1] && hready && !hwrite;
      wrReq = hsel && htrans[1] && hready && hwrite;
      locked = s.ctl0[`ENC_BIT];
      n.softStart = 1'b0;
      n.convTick = 1'b0;
      n.hready = 1'b1;
      seqMode = s.ctl1[`SEQ_POS +: 2];

      // -----------------------------------------------------------
      // Register reads and writes
      // -----------------------------------------------------------
      rdVal = 32'h0000_0000;
      if (rdIdx == `CTL0_IDX) begin
         rdVal[15:0] = {s.ctl0[15:1], 1'b0};
      end else if (rdIdx == `CTL1_IDX) begin
         rdVal[15:0] = {s.ctl1[15:1], s.seqState != SEQ_IDLE};
      end else if (isMem(rdIdx)) begin
         rdVal[11:0] = s.results[memSlot(rdIdx)];
      end else if (isMctl(rdIdx)) begin
         rdVal[7:0] = s.mctl[rdIdx[3:0]];
      end else if (rdIdx == `STAT_IDX) begin
         rdVal[1:0] = {s.tovFlag, s.ovFlag};
      end
      if (rdReq) begin
         n.hrdata = rdVal;
         if (isMem(rdIdx)) begin
            n.unread[memSlot(rdIdx)] = 1'b0;
         end
      end
      n.wrPend = wrReq;
      if (wrReq) begin
         n.wrIdx = rdIdx;
      end
      if (s.wrPend) begin
         if (s.wrIdx == `CTL0_IDX) begin
            n.ctl0 = locked
               ? ((s.ctl0 & `CTL0_LOCK)
                  | (hwdata[15:0] & ~`CTL0_LOCK))
               : hwdata[15:0];
            n.ctl0[`SC_BIT] = 1'b0;
            n.softStart = hwdata[`SC_BIT];
         end else if (s.wrIdx == `CTL1_IDX && !locked) begin
            n.ctl1 = hwdata[15:0] & `CTL1_LOCK;
         end else if (isMctl(s.wrIdx) && !locked) begin
            n.mctl[s.wrIdx[3:0]] = hwdata[7:0];
         end else if (isMem(s.wrIdx)) begin
            n.results[memSlot(s.wrIdx)] = hwdata[11:0];
         end else if (s.wrIdx == `STAT_IDX) begin
            n.ovFlag = s.ovFlag && !hwdata[0];
            n.tovFlag = s.tovFlag && !hwdata[1];
         end
      end

      // -----------------------------------------------------------
      // Converter clock and trigger path
      // -----------------------------------------------------------
      case (s.ctl1[`SSEL_POS +: 2])
         2'h0:    srcTick = oscTick;
         2'h1:    srcTick = auxTick;
         2'h2:    srcTick = mainTick;
         default: srcTick = subMainTick;
      endcase
      tickNow = 1'b0;
      if (srcTick) begin
         if (s.divCnt == s.ctl1[`DIV_POS +: 3]) begin
            n.divCnt = 3'h0;
            tickNow = 1'b1;
         end else begin
            n.divCnt = s.divCnt + 3'h1;
         end
      end
      n.convTick = tickNow;
      case (s.ctl1[`SHS_POS +: 2])
         2'h0:    trigRaw = s.softStart;
         2'h1:    trigRaw = firstTimerOutputOne;
         2'h2:    trigRaw = secondTimerOutputZero;
         default: trigRaw = secondTimerOutputOne;
      endcase
      trigIn = trigRaw ^ s.ctl1[`TRIGGER_INVERT_BIT];
      rise = trigIn && !s.trigPrev;
      n.trigPrev = trigIn;
      enabled = s.ctl0[`ENC_BIT] && s.ctl0[`CORE_BIT];
      shtCode = s.slot[3] ? s.ctl0[`SHT_HI_POS +: 4]
                          : s.ctl0[`SHT_LO_POS +: 4];
      cntInc = s.sampleCnt + 11'h001;
      chainNext = s.ctl0[`MSC_BIT];

      // -----------------------------------------------------------
      // Sequencer
      // -----------------------------------------------------------
      case (s.seqState)
         SEQ_IDLE: begin
            n.slot = s.ctl1[`CSTART_POS +: 4];
            n.sampleCnt = 11'h000;
            if (enabled && rise) begin
               n.seqState = SEQ_SAMPLE;
            end
         end
         SEQ_SAMPLE: begin
            if (s.ctl1[`SHP_BIT]) begin
               if (rise) begin
                  n.tovFlag = 1'b1;
               end
               if (tickNow) begin
                  n.sampleCnt = cntInc;
                  if (cntInc == sampleCycles(shtCode)) begin
                     n.seqState = SEQ_CONVERT;
                  end
               end
            end else if (!trigIn) begin
               n.seqState = SEQ_CONVERT;
            end
         end
         SEQ_CONVERT: begin
            if (rise) begin
               n.tovFlag = 1'b1;
            end
            if (convDone) begin
               n.results[s.slot] = convData;
               if (n.unread[s.slot]) begin
                  n.ovFlag = 1'b1;
               end
               n.unread[s.slot] = 1'b1;
               n.sampleCnt = 11'h000;
               if (!enabled || seqMode == 2'h0) begin
                  n.seqState = SEQ_IDLE;
               end else if (s.mctl[s.slot][`EOS_BIT]
                            && seqMode == 2'h1) begin
                  n.seqState = SEQ_IDLE;
               end else begin
                  if (seqMode == 2'h3 && s.mctl[s.slot][`EOS_BIT]) begin
                     n.slot = s.ctl1[`CSTART_POS +: 4];
                  end else if (seqMode[0]) begin
                     n.slot = s.slot + 4'h1;
                  end
                  n.seqState = chainNext ? SEQ_SAMPLE : SEQ_WAIT;
               end
            end
         end
         SEQ_WAIT: begin
            if (!enabled) begin
               n.seqState = SEQ_IDLE;
            end else if (rise) begin
               n.seqState = SEQ_SAMPLE;
            end
         end
         default: begin
            n.seqState = SEQ_IDLE;
         end
      endcase

      // -----------------------------------------------------------
      // Registered outputs
      // -----------------------------------------------------------
      n.sampleCtl = n.seqState == SEQ_SAMPLE;
      n.busy = n.seqState != SEQ_IDLE;
      n.chanSel = n.mctl[n.slot][3:0];
      n.refSel = n.mctl[n.slot][`SREF_POS +: 3];
      n.corePow = n.ctl0[`CORE_BIT];
      n.refPow = n.ctl0[`REFERENCE_POWER_BIT];
      n.refLvl = n.ctl0[`REFERENCE_POWER_BIT] && n.ctl0[`REFLVL_BIT];
      n.ovIrq = n.ovFlag && n.ctl0[`OVIE_BIT] && globalIrqEnable;
      n.tovIrq = n.tovFlag && n.ctl0[`TOVIE_BIT]
                 && globalIrqEnable;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
         s.ctl0 <= `CTL0_RST;
         s.ctl1 <= `CTL1_RST;
         s.mctl <= {16{`MCTL_RST}};
         s.seqState <= SEQ_IDLE;
      end else if (clkEnable) begin
         s <= n;
      end
   end

   // Every output but hresp is a field of the state flop; hresp is tied OKAY.
   assign hrdata = s.hrdata;
   assign hreadyout = s.hready;
   assign hresp = 1'b0;
   assign sampleControl = s.sampleCtl;
   assign converterClock = s.convTick;
   assign channelSelect = s.chanSel;
   assign referenceSelect = s.refSel;
   assign corePower = s.corePow;
   assign referencePower = s.refPow;
   assign referenceLevelSelect = s.refLvl;
   assign converterBusy = s.busy;
   assign overwriteIrq = s.ovIrq;
   assign timeOverflowIrq = s.tovIrq;

endmodule
`default_nettype wire

/* File: inc/adc_seq_consts.svh */
// Register offsets, field positions and reset values of the converter control.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
// Word indices; the byte address is four times the index.
`define CTL0_IDX   10'h1a0
`define CTL1_IDX   10'h1a2
`define MEM_IDX    10'h140
`define MEM_LAST   10'h15e
`define MCTL_IDX   10'h080
`define MCTL_LAST  10'h08f
`define STAT_IDX   10'h1b0
`define SHT_HI_POS 12
`define SHT_LO_POS 8
`define MSC_BIT    7
`define REFLVL_BIT 6
`define REFERENCE_POWER_BIT  5
`define CORE_BIT   4
`define OVIE_BIT   3
`define TOVIE_BIT  2
`define ENC_BIT    1
`define SC_BIT     0
`define CSTART_POS 12
`define SHS_POS    10
`define SHP_BIT    9
`define TRIGGER_INVERT_BIT   8
`define DIV_POS    5
`define SSEL_POS   3
`define SEQ_POS    1
`define BUSY_BIT   0
`define EOS_BIT    7
`define SREF_POS   4
`define CTL0_LOCK  16'hffc0
`define CTL1_LOCK  16'hfffe
`define CTL0_RST   16'h0000
`define CTL1_RST   16'h0000
`define MCTL_RST   8'h00
`endif

/* File: inc/adc_seq_pkg.sv */
// Types shared by the converter control logic.
package adc_seq_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SAMPLE,
      SEQ_CONVERT,
      SEQ_WAIT
   } seq_state_type;

   typedef struct packed {
      logic [15:0]       ctl0;
      logic [15:0]       ctl1;
      logic [15:0][7:0]  mctl;
      logic [15:0][11:0] results;
      logic [15:0]       unread;
      logic              ovFlag;
      logic              tovFlag;
      seq_state_type     seqState;
      logic [3:0]        slot;
      logic [10:0]       sampleCnt;
      logic [2:0]        divCnt;
      logic              trigPrev;
      logic              softStart;
      logic              wrPend;
      logic [9:0]        wrIdx;
      logic [31:0]       hrdata;
      logic              hready;
      logic              sampleCtl;
      logic              convTick;
      logic              ovIrq;
      logic              tovIrq;
      logic              busy;
      logic [3:0]        chanSel;
      logic [2:0]        refSel;
      logic              corePow;
      logic              refPow;
      logic              refLvl;
   } state_type;
endpackage

/* File: test/adc_core_model.sv */
// Behavioural analog core that answers each sample with a result.
`timescale 1ns/1ns
`default_nettype none
module adc_core_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       sampleControl,
   input  wire logic [3:0] channelSelect,
   input  wire logic [7:0] latency,
   output logic            convDone,
   output logic [11:0]     convData
);
   logic       sampPrev;
   logic [8:0] waitCnt;
   // A conversion begins only when sampling ends. Between results the data
   // lines toggle, so a stale value can never pass for a fresh one.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sampPrev <= 1'b0;
         waitCnt <= 9'h0;
         convDone <= 1'b0;
         convData <= 12'h0;
      end else begin
         sampPrev <= sampleControl;
         convDone <= waitCnt == 9'h1;
         convData <= (waitCnt == 9'h1) ? {8'hc3, channelSelect} : ~convData;
         if (sampPrev && !sampleControl)
            waitCnt <= {1'b0, latency} + 9'h1;
         else if (waitCnt != 9'h0)
            waitCnt <= waitCnt - 9'h1;
      end
   end
endmodule
`default_nettype wire

/* File: test/adc_sequencer_control_regs_properties.sv */
// Port-level assertions for the converter control block.
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control_regs_properties (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        globalIrqEnable,
   input wire logic        sampleControl,
   input wire logic        corePower,
   input wire logic        referencePower,
   input wire logic        referenceLevelSelect,
   input wire logic        converterBusy,
   input wire logic        overwriteIrq,
   input wire logic        timeOverflowIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ---------------------------------------------------------------
   // Read address phase aimed at one 256-byte page of the map.
   // ---------------------------------------------------------------
   sequence rdAt(logic [3:0] page);
      hsel && htrans[1] && hready && !hwrite && haddr[11:8] == page;
   endsequence
   a_result_upper:
      assert property (rdAt(4'h5) |=> hrdata[31:12] == 20'h0)
      else $error("result word upper bits set");
   a_slot_upper:
      assert property (rdAt(4'h2) |=> hrdata[31:8] == 24'h0)
      else $error("slot control upper bits set");
   a_busy_sample:
      assert property (sampleControl |-> converterBusy) else $error("idle");
   a_busy_rise:
      assert property ($rose(converterBusy) |-> $rose(sampleControl))
      else $error("busy without sampling");
   a_ref_level:
      assert property (referenceLevelSelect |-> referencePower)
      else $error("level with reference off");
   a_core_start:
      assert property ($rose(sampleControl) |-> corePower)
      else $error("sampling with core off");
   a_irq_gated:
      assert property (overwriteIrq || timeOverflowIrq |->
         $past(globalIrqEnable)) else $error("irq without global enable");
   a_irq_drop:
      assert property ($fell(globalIrqEnable) |=>
         !overwriteIrq && !timeOverflowIrq) else $error("irq not masked");
endmodule
bind adc_sequencer_control_regs adc_sequencer_control_regs_properties
   u_props (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hready,
   .hrdata, .globalIrqEnable, .sampleControl, .corePower, .referencePower,
   .referenceLevelSelect, .converterBusy, .overwriteIrq, .timeOverflowIrq);
`default_nettype wire

/* File: test/adc_sequencer_control_regs_tb.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control_regs_tb;
   logic        clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        clkEnable = 1'b1, oscTick = 1'b1, globalIrqEnable = 1'b0;
   logic        auxTick = 1'b0, mainTick = 1'b0, subMainTick = 1'b0;
   logic        firstTimerOutputOne = 1'b0, secondTimerOutputZero = 1'b0;
   logic        secondTimerOutputOne = 1'b0, hready, hreadyout, hresp;
   logic        sampleControl, converterClock, corePower, referencePower;
   logic        referenceLevelSelect, converterBusy, overwriteIrq;
   logic        timeOverflowIrq, convDone;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, cnt = 3'h0, referenceSelect;
   logic [3:0]  channelSelect;
   logic [7:0]  coreLat = 8'h3;
   logic [11:0] convData;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
   int          fails = 0, numChecks = 0, hiCnt = 0;
   assign hready = hreadyout;
   adc_sequencer_control_regs u_dut (.clk, .reset_n, .clkEnable, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .oscTick, .auxTick, .mainTick, .subMainTick,
      .firstTimerOutputOne, .secondTimerOutputZero, .secondTimerOutputOne,
      .globalIrqEnable, .convDone, .convData, .sampleControl,
      .converterClock, .channelSelect, .referenceSelect, .corePower,
      .referencePower, .referenceLevelSelect, .converterBusy,
      .overwriteIrq, .timeOverflowIrq);
   adc_core_model u_core (.clk, .reset_n, .sampleControl, .channelSelect,
      .latency(coreLat), .convDone, .convData);
   initial begin
      forever #50 clk = ~clk;
   end
   // Unselected clock sources and timers keep moving so a wrong select shows.
   always @(posedge clk) begin
      cnt <= cnt + 3'h1;
      auxTick <= cnt == 3'h0;
      mainTick <= cnt[0];
      subMainTick <= cnt[1];
      firstTimerOutputOne <= cnt[2];
      secondTimerOutputZero <= cnt[1];
      secondTimerOutputOne <= cnt[2:1] == 2'h0;
   end
   // ---------------------------------------------------------------
   // Bus, wait and compare helpers
   // ---------------------------------------------------------------
   task automatic completeRun();
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic timedOut();
      fails++;
      completeRun();
   endtask
   task automatic chk(input string what, input logic [31:0] e, g);
      numChecks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chkb(input string what, input logic e, g);
      chk(what, {31'h0, e}, {31'h0, g});
   endtask
   task automatic edgeReady();
      int n;
      for (n = 0; n < 99; n++) begin
         @(posedge clk);
         if (hreadyout === 1'b1)
            break;
      end
      if (n >= 99)
         timedOut();
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      edgeReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edgeReady();
      rdat = hrdata;
   endtask
   task automatic rdc(input logic [31:0] a, e, input string what);
      bus(1'b0, a, 32'h0);
      chk(what, e, rdat);
   endtask
   task automatic waitBusy(input logic lvl);
      int n;
      for (n = 0; n < 3000 && converterBusy !== lvl; n++) begin
         @(posedge clk);
         if (sampleControl === 1'b1)
            hiCnt++;
      end
      if (n >= 3000)
         timedOut();
   endtask
   task automatic conv(input logic [31:0] c0);
      hiCnt = 0;
      bus(1'b1, 32'h680, c0);
      waitBusy(1'b1);
      waitBusy(1'b0);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic testConv();
      rdc(32'h680, 32'h0, "first control");
      rdc(32'h214, 32'h0, "slot control 5");
      bus(1'b1, 32'h7f0, 32'h1234);
      rdc(32'h7f0, 32'h0, "unmapped");
      bus(1'b1, 32'h20c, 32'h8a);
      bus(1'b1, 32'h224, 32'h85);
      bus(1'b1, 32'h688, 32'h3200);
      bus(1'b1, 32'h680, 32'h150);
      repeat (2) @(posedge clk);
      chkb("core power", 1'b1, corePower);
      chkb("level while off", 1'b0, referenceLevelSelect);
      conv(32'h153);
      chkb("lower sample", 1'b1, hiCnt inside {[7:10]});
      rdc(32'h518, 32'hc3a, "result 3");
      bus(1'b1, 32'h680, 32'h170);
      bus(1'b1, 32'h688, 32'h9200);
      conv(32'h173);
      chkb("upper sample", 1'b1, hiCnt inside {[3:6]});
      chkb("reference level", 1'b1, referenceLevelSelect);
      rdc(32'h548, 32'hc35, "result 9");
      bus(1'b1, 32'h688, 32'h0);
      rdc(32'h688, 32'h9200, "locked control");
      bus(1'b1, 32'h224, 32'h0);
      rdc(32'h224, 32'h85, "locked slot");
      bus(1'b1, 32'h680, 32'hff52);
      rdc(32'h680, 32'h152, "first control lock");
      $display("conversion test done");
   endtask
   task automatic testFlags();
      conv(32'h15b);
      conv(32'h15b);
      rdc(32'h6c0, 32'h1, "overwrite flag");
      globalIrqEnable <= 1'b1;
      repeat (2) @(posedge clk);
      chkb("overwrite irq", 1'b1, overwriteIrq);
      globalIrqEnable <= 1'b0;
      repeat (2) @(posedge clk);
      chkb("irq masked", 1'b0, overwriteIrq);
      bus(1'b1, 32'h6c0, 32'h1);
      rdc(32'h6c0, 32'h0, "flag cleared");
      bus(1'b1, 32'h680, 32'h150);
      bus(1'b1, 32'h680, 32'h350);
      bus(1'b1, 32'h688, 32'h3200);
      coreLat <= 8'h14;
      bus(1'b1, 32'h680, 32'h357);
      waitBusy(1'b1);
      rdc(32'h688, 32'h3201, "busy bit");
      bus(1'b1, 32'h680, 32'h357);
      globalIrqEnable <= 1'b1;
      waitBusy(1'b0);
      rdc(32'h6c0, 32'h2, "overflow flag");
      chkb("overflow irq", 1'b1, timeOverflowIrq);
      $display("flag test done");
   endtask
   task automatic testSeq();
      int n;
      bus(1'b1, 32'h680, 32'h10);
      bus(1'b1, 32'h688, 32'he22a);
      bus(1'b1, 32'h238, 32'h21);
      bus(1'b1, 32'h23c, 32'h2);
      bus(1'b1, 32'h200, 32'h87);
      chkb("bus response", 1'b0, hresp);
      n = 0;
      repeat (64) begin
         @(posedge clk);
         if (converterClock === 1'b1)
            n++;
      end
      chk("divided clock", 32'h4, n);
      conv(32'h93);
      rdc(32'h570, 32'hc31, "result 14");
      rdc(32'h578, 32'hc32, "result 15");
      rdc(32'h500, 32'hc37, "result 0");
      chk("reference select", 32'h2, {29'h0, referenceSelect});
      chk("channel select", 32'h1, {28'h0, channelSelect});
      $display("sequence test done");
   endtask
   task automatic testTrig();
      bus(1'b1, 32'h680, 32'h10);
      bus(1'b1, 32'h688, 32'h4d00);
      conv(32'h12);
      chk("trigger width", 32'h6, hiCnt);
      $display("trigger test done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      testConv();
      testFlags();
      testSeq();
      testTrig();
      completeRun();
   end
endmodule
`default_nettype wire
